// ==== verilog/sao_pkg.sv ====
// Constants for the serial audio output port
package sao_pkg;
    localparam logic [15:0] SAO_CTRL_ADDR = 16'h081e;
    localparam logic [15:0] SAO_CTRL_RESET = 16'h0000;
    localparam logic [15:0] SAO_CTRL_MASK = 16'h3fff;
    localparam int SAO_LRP_BIT = 13;
    localparam int SAO_EDGE_BIT = 12;
    localparam int SAO_MS_BIT = 11;
    localparam int SAO_BDIV_LSB = 9;
    localparam int SAO_LDIV_LSB = 7;
    localparam int SAO_FST_BIT = 6;
    localparam int SAO_TDM_BIT = 5;
    localparam int SAO_MSB_LSB = 2;
    localparam int SAO_WL_LSB = 0;
    localparam int SAO_WORD_BITS = 24;
    localparam int SAO_CHANNELS = 8;
    localparam int SAO_PINS = 4;
    localparam int SAO_SLOT_BITS = 32;
    localparam int SAO_SLOT_LOG = 5;
    localparam int SAO_CNT_BITS = 10;
    localparam int SAO_BITCNT_BITS = 9;
    localparam int SAO_FIFO_DEPTH = 8;
    localparam logic [9:0] SAO_LR_MASK_1024 = 10'h3ff;
    localparam logic [9:0] SAO_LR_MASK_512 = 10'h1ff;
    localparam logic [9:0] SAO_LR_MASK_256 = 10'h0ff;
    localparam int SAO_WL_24 = 24;
    localparam int SAO_WL_20 = 20;
    localparam int SAO_WL_16 = 16;
    localparam int SAO_DLY_A = 1;
    localparam int SAO_DLY_B = 0;
    localparam int SAO_DLY_C = 8;
    localparam int SAO_DLY_D = 12;
    localparam int SAO_DLY_E = 16;
endpackage

// ==== verilog/sao_out_port.sv ====
// Serial audio output port: control register, clock master/slave, framing and a frame FIFO

module sao_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic rdy;
    } sao_fifo_s;
    sao_fifo_s st_reg, st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign in_ready = st_reg.rdy;
    assign out_valid = st_reg.cnt != '0;
    assign out_data = mem[st_reg.rp];
    assign push = in_valid && st_reg.rdy;
    assign pop = out_ready && out_valid;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wp = (st_reg.wp == AW'(DEPTH - 1)) ? '0 : st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = (st_reg.rp == AW'(DEPTH - 1)) ? '0 : st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
        st_next.rdy = st_next.cnt != (AW+1)'(DEPTH);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_reg <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
        end else begin
            st_reg <= st_next;
        end
        if (push) begin
            mem[st_reg.wp] <= in_data;
        end
    end

    a_fifo_no_overfill: assert property (@(posedge core_clk) disable iff (srst)
        st_reg.cnt <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule

module sao_out_port
    import sao_pkg::*;
#(
    parameter int FIFO_DEPTH = SAO_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Control register port
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [15:0] reg_wr_data,
    output logic [15:0] reg_rd_data,
    // Audio frames from the processing core, channel 0 in the low word
    input wire logic frame_valid,
    output logic frame_ready,
    input wire logic [SAO_CHANNELS*SAO_WORD_BITS-1:0] frame_data,
    // Bit clock pin
    input wire logic bitclk_in,
    output logic bitclk_out,
    output logic bitclk_oe_n,
    // Word clock pin
    input wire logic wordclk_in,
    output logic wordclk_out,
    output logic wordclk_oe_n,
    // Serial data pins
    output logic first_serial_out_pin,
    output logic [SAO_PINS-2:0] serial_out_upper
);
    localparam int FW = SAO_CHANNELS * SAO_WORD_BITS;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] rdata;
        logic [SAO_CNT_BITS-1:0] cnt;
        logic bclk_o;
        logic lr_o;
        logic oe_n;
        logic bclk_prev;
        logic lr_seen;
        logic [SAO_BITCNT_BITS-1:0] bitcnt;
        logic [FW-1:0] frame;
        logic [SAO_PINS-1:0] sd;
    } sao_state_s;
    sao_state_s st_reg, st_next;
    logic fifo_valid, fifo_pop;
    logic [FW-1:0] fifo_data;

    sao_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .in_valid(frame_valid),
        .in_ready(frame_ready),
        .in_data(frame_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    always_comb begin
        int kb, lrb, dly, wl, ch, p, idx;
        logic [SAO_CNT_BITS-1:0] cnt_n, lmask, fbit;
        logic master, lrp, edge_sel, frame_sync_type, tdm, bclk_lvl, lr_lvl, chg, lr_edge, start, half;
        logic [SAO_BITCNT_BITS-1:0] bc;
        kb = 0;
        lrb = 0;
        dly = 0;
        wl = 0;
        ch = 0;
        p = 0;
        idx = 0;
        bc = '0;
        lr_edge = 1'b0;
        start = 1'b0;
        half = 1'b0;
        lmask = SAO_LR_MASK_1024;
        st_next = st_reg;
        fifo_pop = 1'b0;
        if (reg_wr_en && reg_addr == SAO_CTRL_ADDR) begin
            st_next.ctrl = reg_wr_data & SAO_CTRL_MASK;
        end
        st_next.rdata = (reg_addr == SAO_CTRL_ADDR) ? st_reg.ctrl : '0;
        master = st_reg.ctrl[SAO_MS_BIT];
        lrp = st_reg.ctrl[SAO_LRP_BIT];
        edge_sel = st_reg.ctrl[SAO_EDGE_BIT];
        frame_sync_type = st_reg.ctrl[SAO_FST_BIT];
        tdm = st_reg.ctrl[SAO_TDM_BIT];
        st_next.oe_n = ~master;
        case (st_reg.ctrl[SAO_BDIV_LSB +: 2])
            2'b00: kb = 3;
            2'b01: kb = 2;
            2'b10: kb = 1;
            default: kb = 0;
        endcase
        case (st_reg.ctrl[SAO_LDIV_LSB +: 2])
            2'b01: begin lmask = SAO_LR_MASK_512; lrb = 8; end
            2'b10: begin lmask = SAO_LR_MASK_256; lrb = 7; end
            default: begin lmask = SAO_LR_MASK_1024; lrb = 9; end
        endcase
        // Reserved codes fall back to the slowest legal setting
        cnt_n = (st_reg.cnt + 1'b1) & lmask;
        st_next.cnt = cnt_n;
        st_next.bclk_o = cnt_n[kb];
        fbit = cnt_n >> (kb + 1);
        st_next.lr_o = frame_sync_type ? (fbit == '0) : (cnt_n[lrb] ^ lrp);
        bclk_lvl = master ? st_reg.bclk_o : bitclk_in;
        lr_lvl = master ? st_reg.lr_o : wordclk_in;
        st_next.bclk_prev = bclk_lvl;
        chg = edge_sel ? (bclk_lvl & ~st_reg.bclk_prev) : (~bclk_lvl & st_reg.bclk_prev);
        if (chg) begin
            lr_edge = lr_lvl != st_reg.lr_seen;
            start = lr_edge && (lr_lvl == (frame_sync_type ? 1'b1 : lrp));
            st_next.lr_seen = lr_lvl;
            // Saturating count keeps a stalled slave clock from wrapping into valid slots
            if ((frame_sync_type || tdm) ? start : lr_edge) begin
                bc = '0;
            end else if (&st_reg.bitcnt) begin
                bc = st_reg.bitcnt;
            end else begin
                bc = st_reg.bitcnt + 1'b1;
            end
            st_next.bitcnt = bc;
            if (start) begin
                // Underrun sends a silent frame rather than stale samples
                st_next.frame = fifo_valid ? fifo_data : '0;
                fifo_pop = fifo_valid;
            end
            case (st_reg.ctrl[SAO_MSB_LSB +: 3])
                3'b001: dly = SAO_DLY_B;
                3'b010: dly = SAO_DLY_C;
                3'b011: dly = SAO_DLY_D;
                3'b100: dly = SAO_DLY_E;
                default: dly = SAO_DLY_A;
            endcase
            case (st_reg.ctrl[SAO_WL_LSB +: 2])
                2'b01: wl = SAO_WL_20;
                2'b10: wl = SAO_WL_16;
                default: wl = SAO_WL_24;
            endcase
            half = lr_lvl ^ lrp;
            for (int j = 0; j < SAO_PINS; j++) begin
                ch = -1;
                p = 0;
                if (tdm) begin
                    if (j == 0) begin
                        ch = int'(bc >> SAO_SLOT_LOG);
                        p = int'(bc) % SAO_SLOT_BITS;
                    end
                end else if (!frame_sync_type) begin
                    ch = 2 * j + int'(half);
                    p = int'(bc);
                end else if (int'(bc >> SAO_SLOT_LOG) < 2) begin
                    ch = 2 * j + int'(bc >> SAO_SLOT_LOG);
                    p = int'(bc) % SAO_SLOT_BITS;
                end
                idx = p - dly;
                if (ch >= 0 && ch < SAO_CHANNELS && idx >= 0 && idx < wl) begin
                    st_next.sd[j] = st_next.frame[ch * SAO_WORD_BITS + SAO_WORD_BITS - 1 - idx];
                end else begin
                    st_next.sd[j] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.ctrl <= SAO_CTRL_RESET;
            st_reg.oe_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rd_data = st_reg.rdata;
    assign bitclk_out = st_reg.bclk_o;
    assign wordclk_out = st_reg.lr_o;
    assign bitclk_oe_n = st_reg.oe_n;
    assign wordclk_oe_n = st_reg.oe_n;
    assign first_serial_out_pin = st_reg.sd[0];
    assign serial_out_upper = st_reg.sd[SAO_PINS-1:1];

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_change_edge;
        (st_reg.ctrl[SAO_EDGE_BIT] ? $rose(st_reg.bclk_prev) : $fell(st_reg.bclk_prev));
    endsequence

    a_slave_pins: assert property (!st_reg.ctrl[SAO_MS_BIT] |=> bitclk_oe_n && wordclk_oe_n)
        else $error("Clock pins driven while slave");
    a_data_on_edge: assert property ($changed(st_reg.sd) && $stable(st_reg.ctrl) |-> s_change_edge)
        else $error("Data changed off the selected edge");
    a_bclk_div_two: assert property (st_reg.ctrl[SAO_MS_BIT] && st_reg.ctrl[SAO_BDIV_LSB +: 2] == 2'b11
        && $past(st_reg.ctrl) == st_reg.ctrl |=> bitclk_out != $past(bitclk_out))
        else $error("Bit clock not divided by two");
    a_lr_half: assert property (!st_reg.ctrl[SAO_FST_BIT] && st_reg.ctrl[SAO_LDIV_LSB +: 2] == 2'b10
        && $stable(st_reg.ctrl) |-> wordclk_out == (st_reg.cnt[7] ^ st_reg.ctrl[SAO_LRP_BIT]))
        else $error("Word clock level does not follow polarity");
    a_lr_period: assert property (st_reg.ctrl[SAO_LDIV_LSB +: 2] == 2'b10 && st_reg.cnt == 10'h0ff
        |=> st_reg.cnt == 10'h000)
        else $error("Word clock period not 256");
    a_sync_pulse: assert property (st_reg.ctrl[SAO_FST_BIT] && st_reg.ctrl[SAO_BDIV_LSB +: 2] == 2'b11
        && $past(st_reg.ctrl) == st_reg.ctrl && $rose(wordclk_out) |=> wordclk_out ##1 !wordclk_out)
        else $error("Frame pulse not one bit long");
    a_tdm_upper_zero: assert property (st_reg.ctrl[SAO_TDM_BIT] && $past(st_reg.ctrl[SAO_TDM_BIT])
        && $changed(st_reg.bitcnt) |-> serial_out_upper == '0)
        else $error("Upper pins active in TDM");
    a_pad_zero: assert property (st_reg.ctrl[SAO_TDM_BIT] && $changed(st_reg.bitcnt) && $stable(st_reg.ctrl)
        && st_reg.ctrl[SAO_WL_LSB +: 2] == 2'b10 && st_reg.ctrl[SAO_MSB_LSB +: 3] == 3'b001
        && st_reg.bitcnt[SAO_SLOT_LOG-1:0] >= 5'h10 |-> !first_serial_out_pin)
        else $error("Bits after the LSB not zero");
    a_delay_zero: assert property (st_reg.ctrl[SAO_TDM_BIT] && $changed(st_reg.bitcnt) && $stable(st_reg.ctrl)
        && st_reg.ctrl[SAO_MSB_LSB +: 3] == 3'b100 && st_reg.bitcnt[SAO_SLOT_LOG-1:0] < 5'h10
        |-> !first_serial_out_pin)
        else $error("Data before the MSB delay");
endmodule

// ==== verification/sao_rx_model.sv ====
// Receiving converter model: slave clock source and serial data capture
module sao_rx_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Setting: 0 data changes on bit clock fall, 1 on rise
    input wire logic edge_sel,
    // Pins as resolved on the board
    input wire logic bclk,
    input wire logic lr,
    input wire logic sdata,
    output logic bclk_drv,
    output logic lr_drv,
    // Last 32 bits captured in each word clock half, bit 31 first
    output logic [31:0] cap_lo,
    output logic [31:0] cap_hi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] cnt;
    logic bclk_q;
    logic lr_ce;
    logic lr_q;
    logic [31:0] sr;
    // Free-running clocks; word clock moves with the bit clock fall
    assign bclk_drv = cnt[3];
    assign lr_drv = cnt[9];
    always_ff @(posedge core_clk) begin
        cnt <= srst ? 10'h000 : cnt + 10'h001;
        bclk_q <= bclk;
        // Half is known from the launching edge, so a late word clock cannot shift bits
        if (bclk != bclk_q && bclk == edge_sel) begin
            lr_ce <= lr;
        end
        if (bclk != bclk_q && bclk != edge_sel) begin
            lr_q <= lr_ce;
            sr <= {sr[30:0], sdata};
            if (lr_ce != lr_q) begin
                cap_hi <= lr_q ? sr : cap_hi;
                cap_lo <= lr_q ? cap_lo : sr;
                sr <= {31'h0, sdata};
            end
        end
    end
endmodule

// ==== verification/tb_sao_out_port.sv ====
// Testbench for the serial audio output port
module tb_sao_out_port import sao_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] reg_addr = SAO_CTRL_ADDR;
    logic reg_wr_en = 1'b0;
    logic [15:0] reg_wr_data = 16'h0000;
    logic [15:0] reg_rd_data;
    logic frame_valid = 1'b0;
    logic frame_ready;
    logic [SAO_CHANNELS*SAO_WORD_BITS-1:0] frame_data = {{6{24'h0f0f0f}}, 24'h5ac369, 24'hc35a96};
    logic bitclk_out, bitclk_oe_n, wordclk_out, wordclk_oe_n, sd0, bclk_drv, lr_drv;
    logic [2:0] upper;
    logic [31:0] cap_lo, cap_hi;
    logic edge_sel = 1'b0;
    int error_cnt = 0;
    int comparisons = 0;
    int br, lrr, lh;
    int dly [6] = '{1, 0, 8, 12, 16, 1};
    // Tester copy of a clock reaches the pin only while the port has released it
    wire logic bclk_pin = bitclk_oe_n ? bclk_drv : bitclk_out;
    wire logic lr_pin = wordclk_oe_n ? lr_drv : wordclk_out;

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    sao_out_port sao_out_port_inst (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .frame_valid(frame_valid), .frame_ready(frame_ready),
        .frame_data(frame_data), .bitclk_in(bclk_pin), .bitclk_out(bitclk_out), .bitclk_oe_n(bitclk_oe_n),
        .wordclk_in(lr_pin), .wordclk_out(wordclk_out), .wordclk_oe_n(wordclk_oe_n),
        .first_serial_out_pin(sd0), .serial_out_upper(upper));
    sao_rx_model sao_rx_model_inst (.core_clk(core_clk), .srst(srst), .edge_sel(edge_sel), .bclk(bclk_pin),
        .lr(lr_pin), .sdata(sd0), .bclk_drv(bclk_drv), .lr_drv(lr_drv), .cap_lo(cap_lo), .cap_hi(cap_hi));

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic stop_test();
        $display("Errors: %0d, comparisons: %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        tick(1);
        reg_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        reg_addr = a;
        tick(1);
        chk(reg_rd_data, exp);
    endtask

    // Slot of 32 bits: word cut to its length, zero fill, shifted by the MSB delay
    function automatic logic [31:0] expw(input logic [23:0] w, input logic [1:0] wl, input int d);
        logic [23:0] m;
        m = wl == 2'b01 ? 24'hfffff0 : wl == 2'b10 ? 24'hffff00 : 24'hffffff;
        return {w & m, 8'h00} >> d;
    endfunction

    // Counts are exact because every period divides the 1024-cycle window
    task automatic measure(output int b, output int l, output int h);
        logic bq, lq;
        b = 0;
        l = 0;
        h = 0;
        tick(1100);
        bq = bclk_pin;
        lq = lr_pin;
        repeat (1024) begin
            tick(1);
            b += int'(bclk_pin & ~bq);
            l += int'(lr_pin & ~lq);
            h += int'(lr_pin);
            bq = bclk_pin;
            lq = lr_pin;
        end
    endtask

    task automatic s_regs();
        chk({bitclk_oe_n, wordclk_oe_n}, 3);
        chk(frame_ready, 0);
        rd(SAO_CTRL_ADDR, SAO_CTRL_RESET);
        wr(SAO_CTRL_ADDR, 16'hffff);
        rd(SAO_CTRL_ADDR, 16'h3fff);
        wr(16'h081f, 16'h0000);
        rd(16'h081f, 16'h0000);
        rd(SAO_CTRL_ADDR, 16'h3fff);
    endtask

    task automatic s_clocks();
        for (int i = 0; i < 4; i++) begin
            wr(SAO_CTRL_ADDR, {5'h01, 2'(i), 9'h000});
            measure(br, lrr, lh);
            chk(br, 64 << i);
            chk({bitclk_oe_n, wordclk_oe_n}, 0);
        end
        for (int i = 0; i < 3; i++) begin
            wr(SAO_CTRL_ADDR, {7'h04, 2'(i), 7'h00});
            measure(br, lrr, lh);
            chk(lrr, 1 << i);
            chk(lh, 512);
        end
        wr(SAO_CTRL_ADDR, 16'h0840);
        measure(br, lrr, lh);
        chk(lrr, 1);
        chk(lh, 16);
        // Fastest bit clock: the frame pulse lasts one bit, two core cycles
        wr(SAO_CTRL_ADDR, 16'h0e40);
        measure(br, lrr, lh);
        chk(br, 512);
        chk(lrr, 1);
        chk(lh, 2);
    endtask

    task automatic s_data(input logic lrp, input logic edg, input logic ms, input logic [1:0] wl,
        input logic [2:0] msb, input int d);
        wr(SAO_CTRL_ADDR, {2'b00, lrp, edg, ms, 6'h00, msb, wl});
        edge_sel = edg;
        tick(3072);
        chk(lrp ? cap_hi : cap_lo, expw(24'hc35a96, wl, d));
        chk(lrp ? cap_lo : cap_hi, expw(24'h5ac369, wl, d));
    endtask

    task automatic s_tdm(input logic tdm, input logic [4:0] lo, input logic exp, input int d);
        logic seen;
        wr(SAO_CTRL_ADDR, {10'h020, tdm, lo});
        seen = 1'b0;
        tick(1100);
        repeat (1024) begin
            tick(1);
            seen |= |upper;
        end
        chk(seen, exp);
        chk(cap_lo, expw(24'hc35a96, lo[1:0], d));
        chk(cap_hi, expw(24'h5ac369, lo[1:0], d));
    endtask

    task automatic s_drain();
        int n;
        frame_valid = 1'b0;
        n = 0;
        while (frame_ready !== 1'b1 && n < 1100) begin
            tick(1);
            n++;
        end
        if (n == 1100) begin
            chk(0, 1);
        end else begin
            // Seven stored frames remain; the right half of the first zero frame lands a frame later
            tick(10 * 1024);
            chk(cap_lo, 0);
            chk(cap_hi, 0);
        end
    endtask

    initial begin
        tick(3);
        srst = 1'b0;
        frame_valid = 1'b1;
        tick(12);
        s_regs();
        s_clocks();
        for (int i = 0; i < 6; i++) begin
            s_data(0, 0, 1, 2'b10, 3'(i), dly[i]);
        end
        for (int i = 0; i < 3; i++) begin
            s_data(0, 0, 1, 2'(i), 3'b000, 1);
        end
        s_data(1, 0, 1, 2'b00, 3'b001, 0);
        s_data(0, 1, 1, 2'b00, 3'b000, 1);
        s_data(0, 0, 0, 2'b00, 3'b000, 1);
        chk({bitclk_oe_n, wordclk_oe_n}, 3);
        s_tdm(0, 5'h00, 1, 1);
        s_tdm(1, 5'b00110, 0, 0);
        s_tdm(1, 5'b10000, 0, 16);
        s_drain();
        stop_test();
    end
endmodule
